// ---- rsse_alu.sv ----
// combinational datapath: rotates, subtracts, step-and-skip, byte and bit set
`timescale 1ns/100ps
module rsse_alu import rsse_pkg::*; (
  input wire rsse_op_t op,           // operation being executed
  input wire logic [7:0] mem_byte,   // operand read from data memory
  input wire logic [7:0] wreg,       // working register operand
  input wire rsse_flags_t flags_in,  // flags before the operation
  output rsse_alu_out_t res          // result byte, new flags, skip decision
);

  wire with_borrow = (op.code == RSSE_MINUS_WITH_BORROW) ||
                     (op.code == RSSE_BORROW_MINUS_TO_MEMORY);
  wire borrow_in = with_borrow & ~flags_in.carry;
  wire [8:0] diff = {1'b0, wreg} - {1'b0, mem_byte} - {8'h00, borrow_in};
  wire [4:0] diff_lo = {1'b0, wreg[3:0]} - {1'b0, mem_byte[3:0]} - {4'h0, borrow_in};
  wire [7:0] dec_byte = mem_byte - 8'h01;
  wire [7:0] inc_byte = mem_byte + 8'h01;
  wire [7:0] rot_lc = {mem_byte[6:0], flags_in.carry};
  wire [7:0] rot_r = {mem_byte[0], mem_byte[7:1]};
  wire [7:0] rot_rc = {flags_in.carry, mem_byte[7:1]};
  wire [7:0] bit_mask = 8'h01 << op.bit_sel;

  rsse_flags_t sub_flags;
  always_comb begin
    sub_flags.carry = ~diff[8];
    sub_flags.half_carry_flag = ~diff_lo[4];
    sub_flags.zero = (diff[7:0] == 8'h00);
    sub_flags.signed_range_flag = (wreg[7] ^ mem_byte[7]) & (wreg[7] ^ diff[7]);
  end

  always_comb begin
    res.value = mem_byte;
    res.flags = flags_in;
    res.skip = 1'b0;
    case (op.code)
      RSSE_ROTATE_LEFT_VIA_CY_FLAG, RSSE_ROTATE_LEFT_CY_TO_WREG: begin
        res.value = rot_lc;
        res.flags.carry = mem_byte[7];
      end
      RSSE_ROTATE_RIGHT_IN_PLACE, RSSE_ROTATE_RIGHT_TO_WREG: begin
        res.value = rot_r;
      end
      RSSE_ROTATE_RIGHT_VIA_CY_FLAG, RSSE_ROTATE_RIGHT_CY_TO_WREG: begin
        res.value = rot_rc;
        res.flags.carry = mem_byte[0];
      end
      RSSE_MINUS_WITH_BORROW, RSSE_BORROW_MINUS_TO_MEMORY,
      RSSE_MINUS_TO_WREG, RSSE_MINUS_TO_MEMORY: begin
        res.value = diff[7:0];
        res.flags = sub_flags;
      end
      RSSE_DECREMENT_SKIP_ZERO, RSSE_DECREMENT_SKIP_ZERO_TO_WREG: begin
        res.value = dec_byte;
        res.skip = (dec_byte == 8'h00);
      end
      RSSE_INCREMENT_SKIP_ZERO, RSSE_INCREMENT_SKIP_ZERO_TO_WREG: begin
        res.value = inc_byte;
        res.skip = (inc_byte == 8'h00);
      end
      RSSE_SKIP_BIT_NONZERO: begin
        res.skip = |(mem_byte & bit_mask);
      end
      RSSE_SET_BYTE: begin
        res.value = RSSE_BYTE_ONES;
      end
      RSSE_SET_BIT: begin
        res.value = mem_byte | bit_mask;
      end
      default: begin
        res.value = mem_byte;
      end
    endcase
  end

endmodule : rsse_alu

// ---- rsse_apb.sv ----
// apb slave front end: decode, write strobes, registered read data
`timescale 1ns/100ps
module rsse_apb import rsse_pkg::*; #(
  parameter int PADDR_W = RSSE_PADDR_W  // apb address width
) (
  input wire logic mclk,                // core clock
  input wire logic rstn,                // async reset, active low
  input wire logic ce,                  // clock enable
  input wire logic psel,                // apb select
  input wire logic penable,             // apb access phase
  input wire logic pwrite,              // apb direction
  input wire logic [PADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata,       // apb write data
  output logic [31:0] prdata,           // apb read data
  output logic pready,                  // apb ready
  output logic pslverr,                 // apb error on unmapped address
  input wire logic [31:0] rd_wreg,      // working register readback
  input wire logic [31:0] rd_flags,     // flag register readback
  input wire logic [31:0] rd_stat,      // status register readback
  output logic wr_wreg,                 // write strobe, working register
  output logic wr_flags,                // write strobe, flag register
  output logic [7:0] wr_data            // write data byte
);

  // index 0 means unmapped
  function automatic logic [1:0] reg_index(input logic [PADDR_W-1:0] a);
    if (a == PADDR_W'(RSSE_OFS_WREG)) begin
      return 2'h1;
    end else if (a == PADDR_W'(RSSE_OFS_FLAGS)) begin
      return 2'h2;
    end else if (a == PADDR_W'(RSSE_OFS_STAT)) begin
      return 2'h3;
    end else begin
      return 2'h0;
    end
  endfunction : reg_index

  wire [1:0] idx = reg_index(paddr);
  // a setup cycle lost to a low enable is made up in the access phase with one wait state
  logic loaded_q;
  wire access = psel & penable & ce & loaded_q;
  wire setup = psel & ce & ~loaded_q;
  wire [31:0] rd_mux = (idx == 2'h1) ? rd_wreg :
                       (idx == 2'h2) ? rd_flags :
                       (idx == 2'h3) ? rd_stat : 32'h0000_0000;

  logic [31:0] prdata_q;
  // read data captured in setup so the access phase needs no wait state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
      loaded_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      loaded_q <= 1'b1;
    end else if (access) begin
      loaded_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = penable & ce & loaded_q;
  assign pslverr = psel & penable & (idx == 2'h0);
  assign wr_wreg = access & pwrite & (reg_index(paddr) == 2'h1);
  assign wr_flags = access & pwrite & (reg_index(paddr) == 2'h2);
  assign wr_data = pwdata[7:0];

endmodule : rsse_apb

// ---- rsse_exec.sv ----
// execution unit for rotate, subtract, step-and-skip and set operations
`timescale 1ns/100ps
// Notes on behaviour
// - in-place rotate left via carry: bits shift up, old carry to bit 0, bit 7 to carry
// - rotate left via carry to working register; memory kept; bit 7 still to carry
// - in-place rotate right: bit 0 wraps into bit 7; flags untouched
// - rotate right into working register; memory kept; flags untouched
// - in-place rotate right via carry: old carry to bit 7, bit 0 to carry
// - rotate right via carry into working register; memory kept; carry from bit 0
// - subtract with borrow: wreg minus memory minus inverted carry
// - memory form of subtract with borrow writes memory, updates four arithmetic flags
// - subtract carry is 0 on negative result, 1 on zero or positive
// - plain subtract writes wreg minus memory to wreg, updates four flags
// - memory form of plain subtract stores difference to memory, same flags
// - decrement memory in place, skip next when zero, no flag change
// - decrement into working register, memory kept, skip when zero
// - increment memory in place, skip next when wrapped to zero, no flags
// - increment into working register, memory kept, skip when zero
// - every conditional skip operation takes two instruction cycles
// - skip next when the selected memory bit is 1; no flag change
// - byte set writes all ones to memory, no flag change
// - bit set forces only the selected bit to 1, flags unchanged
module rsse_exec import rsse_pkg::*; #(
  parameter int PADDR_W = RSSE_PADDR_W  // apb address width
) (
  input wire logic mclk,                        // core clock, 200 MHz
  input wire logic rstn,                        // async reset, active low
  input wire logic ce,                          // clock enable, freezes all state
  input wire logic psel,                        // apb select
  input wire logic penable,                     // apb access phase
  input wire logic pwrite,                      // apb direction
  input wire logic [PADDR_W-1:0] paddr,         // apb byte address
  input wire logic [31:0] pwdata,               // apb write data
  output logic [31:0] prdata,                   // apb read data
  output logic pready,                          // apb ready
  output logic pslverr,                         // apb error
  input wire logic op_valid,                    // sequencer offers an operation
  output logic op_ready,                        // unit idle and takes it
  input wire rsse_op_t op,                      // operation code, address, bit
  output logic mem_rd,                          // data memory read request
  output logic [RSSE_ADDR_W-1:0] mem_raddr,     // data memory read address
  input wire logic [7:0] mem_rdata,             // read data, one cycle after mem_rd
  output logic mem_we,                          // data memory write pulse
  output logic [RSSE_ADDR_W-1:0] mem_waddr,     // data memory write address
  output logic [7:0] mem_wdata,                 // data memory write data
  output logic done,                            // operation finished pulse
  output logic skip,                            // skip next instruction, with done
  output logic [7:0] wreg,                      // working register
  output rsse_flags_t flags                     // status flags
);

  rsse_state_t state_q, state_d;
  rsse_op_t op_q;
  logic [7:0] wreg_q;
  rsse_flags_t flags_q;
  logic mem_we_q;
  logic [RSSE_ADDR_W-1:0] mem_waddr_q;
  logic [7:0] mem_wdata_q;
  logic done_q;
  logic skip_q;
  logic skip_pend_q;
  logic last_skip_q;
  rsse_alu_out_t alu_res;
  logic wr_wreg;
  logic wr_flags;
  logic [7:0] wr_data;

  wire take_op = op_valid & op_ready & ce;
  wire exec_fire = (state_q == RSSE_EXEC) & ce;
  wire dummy_fire = (state_q == RSSE_DUMMY) & ce;
  wire cur_skip_op = op_is_skip(op_q.code);
  wire cur_to_mem = op_to_mem(op_q.code);
  wire cur_to_wreg = op_to_wreg(op_q.code);
  wire busy = (state_q != RSSE_IDLE);

  wire [31:0] rd_wreg = {24'h00_0000, wreg_q};
  wire [31:0] rd_flags = {28'h000_0000, flags_q};
  wire [31:0] rd_stat = {19'h0_0000, op_q.code, 6'h00, last_skip_q, busy};

  rsse_apb #(
    .PADDR_W(PADDR_W)
  ) u_apb (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rd_wreg(rd_wreg),
    .rd_flags(rd_flags),
    .rd_stat(rd_stat),
    .wr_wreg(wr_wreg),
    .wr_flags(wr_flags),
    .wr_data(wr_data)
  );

  rsse_alu u_alu (
    .op(op_q),
    .mem_byte(mem_rdata),
    .wreg(wreg_q),
    .flags_in(flags_q),
    .res(alu_res)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      RSSE_IDLE: begin
        if (op_valid) begin
          state_d = RSSE_FETCH;
        end
      end
      RSSE_FETCH: begin
        state_d = RSSE_EXEC;
      end
      RSSE_EXEC: begin
        // skip operations spend one more cycle while the next fetch is discarded
        state_d = cur_skip_op ? RSSE_DUMMY : RSSE_IDLE;
      end
      RSSE_DUMMY: begin
        state_d = RSSE_IDLE;
      end
      default: begin
        state_d = RSSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RSSE_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op_q <= '0;
    end else if (take_op) begin
      op_q <= op;
    end
  end

  // execution result beats a software write landing in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wreg_q <= RSSE_WREG_RST;
    end else if (exec_fire && cur_to_wreg) begin
      wreg_q <= alu_res.value;
    end else if (wr_wreg) begin
      wreg_q <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= RSSE_FLAGS_RST;
    end else if (exec_fire) begin
      flags_q <= alu_res.flags;
    end else if (wr_flags) begin
      flags_q <= wr_data[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_we_q <= 1'b0;
      mem_waddr_q <= '0;
      mem_wdata_q <= 8'h00;
    end else if (ce) begin
      mem_we_q <= exec_fire & cur_to_mem;
      if (exec_fire && cur_to_mem) begin
        mem_waddr_q <= op_q.addr;
        mem_wdata_q <= alu_res.value;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
      skip_pend_q <= 1'b0;
      last_skip_q <= 1'b0;
    end else if (ce) begin
      done_q <= (exec_fire & ~cur_skip_op) | dummy_fire;
      skip_q <= dummy_fire & skip_pend_q;
      if (exec_fire) begin
        skip_pend_q <= alu_res.skip;
      end
      if (dummy_fire) begin
        last_skip_q <= skip_pend_q;
      end else if (exec_fire) begin
        last_skip_q <= 1'b0;
      end
    end
  end

  assign op_ready = (state_q == RSSE_IDLE);
  assign mem_rd = (state_q == RSSE_FETCH);
  assign mem_raddr = op_q.addr;
  assign mem_we = mem_we_q;
  assign mem_waddr = mem_waddr_q;
  assign mem_wdata = mem_wdata_q;
  assign done = done_q;
  assign skip = skip_q;
  assign wreg = wreg_q;
  assign flags = flags_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rot_left_mem;
    exec_fire && op_q.code == RSSE_ROTATE_LEFT_VIA_CY_FLAG |=>
      mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(flags_q.carry)} &&
      flags_q.carry == $past(mem_rdata[7]);
  endproperty
  a_rot_left_mem: assert property (p_rot_left_mem) else $error("rotate left via carry wrong");

  property p_rot_left_wreg;
    exec_fire && op_q.code == RSSE_ROTATE_LEFT_CY_TO_WREG |=>
      !mem_we && wreg_q == {$past(mem_rdata[6:0]), $past(flags_q.carry)} &&
      flags_q.carry == $past(mem_rdata[7]);
  endproperty
  a_rot_left_wreg: assert property (p_rot_left_wreg) else $error("rotate left to wreg wrong");

  property p_rot_right_mem;
    exec_fire && op_q.code == RSSE_ROTATE_RIGHT_IN_PLACE |=>
      mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(flags_q);
  endproperty
  a_rot_right_mem: assert property (p_rot_right_mem) else $error("rotate right in place wrong");

  property p_rot_right_cy_mem;
    exec_fire && op_q.code == RSSE_ROTATE_RIGHT_VIA_CY_FLAG |=>
      mem_wdata == {$past(flags_q.carry), $past(mem_rdata[7:1])} &&
      flags_q.carry == $past(mem_rdata[0]);
  endproperty
  a_rot_right_cy_mem: assert property (p_rot_right_cy_mem) else $error("rotate right carry bad");

  property p_sbc_value;
    exec_fire && op_q.code == RSSE_MINUS_WITH_BORROW |=>
      wreg_q == 8'($past(wreg_q) - $past(mem_rdata) - {7'h00, ~$past(flags_q.carry)});
  endproperty
  a_sbc_value: assert property (p_sbc_value) else $error("subtract with borrow value wrong");

  property p_sub_carry;
    exec_fire && op_q.code == RSSE_MINUS_TO_MEMORY |=>
      flags_q.carry == ($past(wreg_q) >= $past(mem_rdata)) &&
      flags_q.zero == (mem_wdata == 8'h00);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry or zero wrong");

  property p_skip_two_cycles;
    exec_fire && cur_skip_op |=> (state_q == RSSE_DUMMY && !done) and (ce |=> done);
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip op not two cycles");

  property p_dec_skip;
    exec_fire && op_q.code == RSSE_DECREMENT_SKIP_ZERO && mem_rdata == 8'h01 |=>
      (mem_we && mem_wdata == 8'h00 && $stable(flags_q)) and (ce |=> done && skip);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip missed");

  property p_bit_skip;
    exec_fire && op_q.code == RSSE_SKIP_BIT_NONZERO |=>
      !mem_we and (ce |=> done && skip == $past(mem_rdata[op_q.bit_sel], 2));
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit test skip wrong");

  property p_set_byte;
    exec_fire && op_q.code == RSSE_SET_BYTE |=> mem_we && mem_wdata == 8'hFF && $stable(flags_q);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("byte set wrong");

  property p_set_bit;
    exec_fire && op_q.code == RSSE_SET_BIT |=>
      mem_wdata == ($past(mem_rdata) | (8'h01 << op_q.bit_sel)) && $stable(flags_q);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

  property p_rot_right_wreg;
    exec_fire && op_q.code == RSSE_ROTATE_RIGHT_TO_WREG |=>
      !mem_we &&
      wreg_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} &&
      $stable(flags_q);
  endproperty
  a_rot_right_wreg: assert property (p_rot_right_wreg) else $error("rotate to wreg bad");

  property p_sbc_mem;
    exec_fire && op_q.code == RSSE_BORROW_MINUS_TO_MEMORY |=>
      mem_we &&
      mem_wdata == 8'($past(wreg_q) - $past(mem_rdata) - {7'h00, ~$past(flags_q.carry)}) &&
      flags_q.zero == (mem_wdata == 8'h00);
  endproperty
  a_sbc_mem: assert property (p_sbc_mem) else $error("borrow subtract to memory bad");

  property p_dec_wreg;
    exec_fire && op_q.code == RSSE_DECREMENT_SKIP_ZERO_TO_WREG |=>
      !mem_we &&
      wreg_q == 8'($past(mem_rdata) - 8'h01) &&
      $stable(flags_q);
  endproperty
  a_dec_wreg: assert property (p_dec_wreg) else $error("decrement to wreg bad");

  property p_inc_mem;
    exec_fire && op_q.code == RSSE_INCREMENT_SKIP_ZERO |=>
      mem_we &&
      mem_wdata == 8'($past(mem_rdata) + 8'h01) &&
      $stable(flags_q);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment in place bad");

  property p_sub_flags;
    exec_fire && op_q.code == RSSE_MINUS_TO_WREG |=>
      flags_q.half_carry_flag == ($past(wreg_q[3:0]) >= $past(mem_rdata[3:0])) &&
      flags_q.signed_range_flag ==
        (($past(wreg_q[7]) != $past(mem_rdata[7])) && (wreg_q[7] != $past(wreg_q[7])));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags bad");

  c_sub_neg: cover property (exec_fire && op_q.code == RSSE_MINUS_TO_WREG ##1 !flags_q.carry);
  c_skip_taken: cover property (done && skip);
  c_rot_mem: cover property (exec_fire && op_q.code == RSSE_ROTATE_RIGHT_VIA_CY_FLAG);
  c_apb_write: cover property (wr_wreg);

endmodule : rsse_exec

// ---- rsse_mem_model.sv ----
// data memory model on the far side of the execution unit
`timescale 1ns/100ps
module rsse_mem_model import rsse_pkg::*; (
  input wire logic mclk,                        // core clock
  input wire logic mem_rd,                      // read request
  input wire logic [RSSE_ADDR_W-1:0] mem_raddr, // read address
  output logic [7:0] mem_rdata,                 // read data, one cycle after the request
  input wire logic mem_we,                      // write pulse
  input wire logic [RSSE_ADDR_W-1:0] mem_waddr, // write address
  input wire logic [7:0] mem_wdata              // write data
);
  logic [7:0] mem [0:(1<<RSSE_ADDR_W)-1];

  initial mem_rdata = 8'h00;

  // outside its read slot the data toggles, so a sample an odd number of cycles late reads inverted data
  always @(posedge mclk) begin
    if (mem_rd)
      mem_rdata <= mem[mem_raddr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end
endmodule : rsse_mem_model

// ---- rsse_pkg.sv ----
// shared constants, types and opcode helpers for the rotate/subtract/skip execution block
package rsse_pkg;

  localparam int RSSE_ADDR_W = 8;
  localparam int RSSE_PADDR_W = 8;

  localparam logic [7:0] RSSE_OFS_WREG = 8'h00;
  localparam logic [7:0] RSSE_OFS_FLAGS = 8'h04;
  localparam logic [7:0] RSSE_OFS_STAT = 8'h08;

  localparam logic [7:0] RSSE_WREG_RST = 8'h00;
  localparam logic [3:0] RSSE_FLAGS_RST = 4'h0;
  localparam logic [7:0] RSSE_BYTE_ONES = 8'hFF;

  localparam int RSSE_STAT_BUSY = 0;
  localparam int RSSE_STAT_SKIP = 1;
  localparam int RSSE_STAT_CODE_LSB = 8;

  typedef enum logic [4:0] {
    RSSE_ROTATE_LEFT_VIA_CY_FLAG     = 5'b00000,
    RSSE_ROTATE_LEFT_CY_TO_WREG      = 5'b00001,
    RSSE_ROTATE_RIGHT_IN_PLACE       = 5'b00010,
    RSSE_ROTATE_RIGHT_TO_WREG        = 5'b00011,
    RSSE_ROTATE_RIGHT_VIA_CY_FLAG    = 5'b00100,
    RSSE_ROTATE_RIGHT_CY_TO_WREG     = 5'b00101,
    RSSE_MINUS_WITH_BORROW           = 5'b00110,
    RSSE_BORROW_MINUS_TO_MEMORY      = 5'b00111,
    RSSE_MINUS_TO_WREG               = 5'b01000,
    RSSE_MINUS_TO_MEMORY             = 5'b01001,
    RSSE_DECREMENT_SKIP_ZERO         = 5'b01010,
    RSSE_DECREMENT_SKIP_ZERO_TO_WREG = 5'b01011,
    RSSE_INCREMENT_SKIP_ZERO         = 5'b01100,
    RSSE_INCREMENT_SKIP_ZERO_TO_WREG = 5'b01101,
    RSSE_SKIP_BIT_NONZERO            = 5'b01110,
    RSSE_SET_BYTE                    = 5'b01111,
    RSSE_SET_BIT                     = 5'b10000
  } rsse_code_t;

  typedef enum logic [1:0] {
    RSSE_IDLE  = 2'b00,
    RSSE_FETCH = 2'b01,
    RSSE_EXEC  = 2'b10,
    RSSE_DUMMY = 2'b11
  } rsse_state_t;

  typedef struct packed {
    logic signed_range_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } rsse_flags_t;

  typedef struct packed {
    rsse_code_t code;
    logic [RSSE_ADDR_W-1:0] addr;
    logic [2:0] bit_sel;
  } rsse_op_t;

  typedef struct packed {
    logic [7:0] value;
    rsse_flags_t flags;
    logic skip;
  } rsse_alu_out_t;

  function automatic logic op_to_mem(input rsse_code_t c);
    return c inside {RSSE_ROTATE_LEFT_VIA_CY_FLAG, RSSE_ROTATE_RIGHT_IN_PLACE,
                     RSSE_ROTATE_RIGHT_VIA_CY_FLAG, RSSE_BORROW_MINUS_TO_MEMORY,
                     RSSE_MINUS_TO_MEMORY, RSSE_DECREMENT_SKIP_ZERO,
                     RSSE_INCREMENT_SKIP_ZERO, RSSE_SET_BYTE, RSSE_SET_BIT};
  endfunction : op_to_mem

  function automatic logic op_to_wreg(input rsse_code_t c);
    return c inside {RSSE_ROTATE_LEFT_CY_TO_WREG, RSSE_ROTATE_RIGHT_TO_WREG,
                     RSSE_ROTATE_RIGHT_CY_TO_WREG, RSSE_MINUS_WITH_BORROW,
                     RSSE_MINUS_TO_WREG, RSSE_DECREMENT_SKIP_ZERO_TO_WREG,
                     RSSE_INCREMENT_SKIP_ZERO_TO_WREG};
  endfunction : op_to_wreg

  function automatic logic op_is_skip(input rsse_code_t c);
    return c inside {RSSE_DECREMENT_SKIP_ZERO, RSSE_DECREMENT_SKIP_ZERO_TO_WREG,
                     RSSE_INCREMENT_SKIP_ZERO, RSSE_INCREMENT_SKIP_ZERO_TO_WREG,
                     RSSE_SKIP_BIT_NONZERO};
  endfunction : op_is_skip

endpackage : rsse_pkg

// ---- tb_top.sv ----
// testbench for the rotate/subtract/skip execution unit
`timescale 1ns/100ps
module tb_top import rsse_pkg::*; ;
  logic mclk, rstn, ce, psel, penable, pwrite, pready, pslverr;
  logic [RSSE_PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic op_valid, op_ready, mem_rd, mem_we, done, skip, e;
  rsse_op_t op;
  logic [RSSE_ADDR_W-1:0] mem_raddr, mem_waddr;
  logic [7:0] mem_rdata, mem_wdata, wreg;
  rsse_flags_t flags;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  rsse_exec rsse_exec_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_ready(op_ready), .op(op), .mem_rd(mem_rd),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .done(done), .skip(skip), .wreg(wreg), .flags(flags));

  rsse_mem_model rsse_mem_model_inst (.mclk(mclk), .mem_rd(mem_rd), .mem_raddr(mem_raddr),
    .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // a stuck handshake ends here; the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; entered and left just after a rising edge
  task apb(input logic wr, input logic [RSSE_PADDR_W-1:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // s = {mem, wreg, flags, bit}, x = expected {mem, wreg, flags, skip}
  task tcase(input rsse_code_t c, input logic [7:0] a, input logic [23:0] s,
             input logic [23:0] x);
    int n;
    logic sk;
    apb(1'b1, RSSE_OFS_WREG, {24'h0, s[15:8]}, q, e);
    apb(1'b1, RSSE_OFS_FLAGS, {28'h0, s[7:4]}, q, e);
    rsse_mem_model_inst.mem[a] = s[23:16];
    op_valid <= 1'b1;
    op <= '{code: c, addr: a, bit_sel: s[2:0]};
    do @(posedge mclk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (done !== 1'b1);
    sk = skip;
    @(posedge mclk);
    #1;
    chk("cycles", n, (c inside {[RSSE_DECREMENT_SKIP_ZERO:RSSE_SKIP_BIT_NONZERO]}) ? 3 : 2);
    chk("mem", rsse_mem_model_inst.mem[a], x[23:16]);
    chk("wreg", wreg, x[15:8]);
    chk("flags", flags, x[7:4]);
    chk("skip", sk, x[0]);
    @(posedge mclk);
  endtask : tcase

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    op_valid = 1'b0;
    op = '0;
    repeat (16) @(posedge mclk);
    #1;
    chk("wreg_rst", wreg, RSSE_WREG_RST);
    chk("flags_rst", flags, RSSE_FLAGS_RST);
    chk("ready_rst", op_ready, 1'b1);
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apb(1'b0, RSSE_OFS_FLAGS, 32'h0, q, e);
    chk("flags_rd", q, 32'h0);
    apb(1'b1, RSSE_OFS_WREG, 32'hFFFF_FFA5, q, e);
    apb(1'b0, RSSE_OFS_WREG, 32'h0, q, e);
    chk("wreg_rd", q, 32'h0000_00A5);
    apb(1'b1, 8'h0C, 32'h0000_00FF, q, e);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_wr", wreg, 8'hA5);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("unmapped_rd", q, 32'h0);
    tcase(RSSE_ROTATE_LEFT_VIA_CY_FLAG, 8'h00, 24'h81_5A_0_0, 24'h02_5A_1_0);
    tcase(RSSE_ROTATE_LEFT_CY_TO_WREG, 8'h11, 24'h40_00_F_0, 24'h40_81_E_0);
    tcase(RSSE_ROTATE_RIGHT_IN_PLACE, 8'h22, 24'h01_33_5_0, 24'h80_33_5_0);
    tcase(RSSE_ROTATE_RIGHT_TO_WREG, 8'h33, 24'h03_00_A_0, 24'h03_81_A_0);
    tcase(RSSE_ROTATE_RIGHT_VIA_CY_FLAG, 8'h44, 24'h02_00_1_0, 24'h81_00_0_0);
    tcase(RSSE_ROTATE_RIGHT_CY_TO_WREG, 8'h55, 24'h01_77_0_0, 24'h01_00_1_0);
    tcase(RSSE_MINUS_WITH_BORROW, 8'h66, 24'h01_10_0_0, 24'h01_0E_1_0);
    tcase(RSSE_BORROW_MINUS_TO_MEMORY, 8'h77, 24'h01_80_1_0, 24'h7F_80_9_0);
    tcase(RSSE_MINUS_TO_WREG, 8'h88, 24'h05_05_0_0, 24'h05_00_7_0);
    tcase(RSSE_MINUS_TO_MEMORY, 8'h99, 24'h02_01_F_0, 24'hFF_01_0_0);
    tcase(RSSE_DECREMENT_SKIP_ZERO, 8'hAA, 24'h01_12_6_0, 24'h00_12_6_1);
    tcase(RSSE_DECREMENT_SKIP_ZERO, 8'hAA, 24'h00_12_6_0, 24'hFF_12_6_0);
    tcase(RSSE_DECREMENT_SKIP_ZERO_TO_WREG, 8'hBB, 24'h01_34_9_0, 24'h01_00_9_1);
    tcase(RSSE_DECREMENT_SKIP_ZERO_TO_WREG, 8'hBB, 24'h02_34_9_0, 24'h02_01_9_0);
    tcase(RSSE_INCREMENT_SKIP_ZERO, 8'hCC, 24'hFF_00_3_0, 24'h00_00_3_1);
    tcase(RSSE_INCREMENT_SKIP_ZERO, 8'hCC, 24'h7F_00_3_0, 24'h80_00_3_0);
    tcase(RSSE_INCREMENT_SKIP_ZERO_TO_WREG, 8'hDD, 24'hFF_55_C_0, 24'hFF_00_C_1);
    tcase(RSSE_INCREMENT_SKIP_ZERO_TO_WREG, 8'hDD, 24'hFE_55_C_0, 24'hFE_FF_C_0);
    tcase(RSSE_SKIP_BIT_NONZERO, 8'hEE, 24'h08_00_2_3, 24'h08_00_2_1);
    tcase(RSSE_SKIP_BIT_NONZERO, 8'hEE, 24'hF7_00_2_3, 24'hF7_00_2_0);
    tcase(RSSE_SET_BYTE, 8'hFF, 24'h12_00_B_0, 24'hFF_00_B_0);
    tcase(RSSE_SET_BIT, 8'h01, 24'h00_00_4_7, 24'h80_00_4_0);
    tcase(RSSE_SET_BIT, 8'h01, 24'h5A_00_4_0, 24'h5B_00_4_0);
    apb(1'b0, RSSE_OFS_FLAGS, 32'h0, q, e);
    chk("flags_rd", q, 32'h0000_0004);
    apb(1'b0, RSSE_OFS_STAT, 32'h0, q, e);
    chk("stat_rd", q, {19'h0_0000, RSSE_SET_BIT, 8'h00});
    chk("stat_err", e, 1'b0);
    // a write begun with the enable low must wait until it returns
    ce <= 1'b0;
    fork
      apb(1'b1, RSSE_OFS_WREG, 32'h0000_003C, q, e);
      begin
        repeat (4) @(posedge mclk);
        chk("ce_frozen", wreg, 8'h00);
        ce <= 1'b1;
      end
    join
    chk("ce_wreg", wreg, 8'h3C);
    conclude();
  end
endmodule : tb_top
